/* File: core/ssr_consts.svh */
// Constants for the status and service request block
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH
`define SSR_IC_ALARM 7
`define SSR_IC_HEATER 4
`define SSR_IC_SF_SECOND 1
`define SSR_IC_SF_FIRST 0
`define SSR_IC_DEFINED 8'h93
`define SSR_SE_OPC 7
`define SSR_SE_QUERY_ERR 5
`define SSR_SE_DEVICE_ERR 4
`define SSR_SE_EXEC_ERR 3
`define SSR_SE_CMD_ERR 2
`define SSR_SE_POWER_ON 0
`define SSR_SE_DEFINED 8'hBD
`define SSR_SB_RQS 6
`define SSR_SB_SE 5
`define SSR_SB_MAV 4
`define SSR_SB_IE 3
`define SSR_SB_DEFINED 8'h38
`define SSR_BYTE_ZERO 8'h00
`define SSR_LINE_LEN 32
`define SSR_SYNC_ZERO 3'h0
`define SSR_CMD_SET_IC_MASK 4'h1
`define SSR_CMD_SET_SE_MASK 4'h2
`define SSR_CMD_SET_SR_MASK 4'h3
`define SSR_CMD_CLEAR 4'h4
`define SSR_CMD_OPC 4'h5
`define SSR_CMD_RD_IC 4'h6
`define SSR_CMD_RD_IC_MASK 4'h7
`define SSR_CMD_RD_SE 4'h8
`define SSR_CMD_RD_SE_MASK 4'h9
`define SSR_CMD_RD_SB 4'hA
`define SSR_CMD_RD_SR_MASK 4'hB
`define SSR_CMD_CATALOG 4'hC
`endif

/* File: core/ssr_pkg.sv */
// Types for the status and service request block
package ssr_pkg;
  typedef enum logic [1:0] {
    SSR_IDLE = 2'b00,
    SSR_OPC_WAIT = 2'b01
  } ssr_opc_t;
  typedef struct packed {
    logic [2:0] alarm_sy;
    logic [2:0] heater_sy;
    logic [2:0] sf1_sy;
    logic [2:0] sf2_sy;
    logic [7:0] ic_held;
    logic [7:0] ic_mask;
    logic [7:0] se_flags;
    logic [7:0] se_mask;
    logic [7:0] sr_mask;
    logic power_seen;
    ssr_opc_t opc_state;
    logic [7:0] rsp_data;
    logic rsp_valid;
    logic srq;
    logic [7:0] last_cmd;
    logic [7:0] last_rsp;
  } ssr_state_t;
endpackage : ssr_pkg

/* File: core/ssr_status.sv */
// Status registers, summary byte and service request logic
// Operation
// - Instrument condition bit 7 follows any asserted alarm.
// - Instrument condition bit 4 follows a heater fault.
// - Bits 0 and 1 flag sensor faults on first and second inputs.
// - Summary bit 3 is nonzero AND of condition and its mask.
// - Event bit 7 set when pending operations finish after request.
// - Event bit 5 set on a query syntax error.
// - Event bit 4 set on a device error.
// - Event bit 3 set when valid command cannot execute.
// - Event bit 2 set on a command syntax error.
// - Event bit 0 set when power comes on.
// - Summary bit 5 is nonzero AND of events and event mask.
// - Summary bit 4 set while an unread response waits.
// - Summary bit 6 is the request for service indication.
// - Service request raised when summary AND request mask nonzero.
// - Request mask is writable, readable back and retained.
// - Condition register returned on the system status query.
// - Catalog query answers with the allowed value list.
// - Keyword short form is four letters, three if fourth vowel.
// - Last received command and last response are retained.
// - Clear command clears events, errors and message available.
`timescale 1ns/1ps
`include "ssr_consts.svh"
module ssr_status
  import ssr_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic alarm_pin,
  input wire logic heater_fault_pin,
  input wire logic sensor_fault_first_input,
  input wire logic sensor_fault_second_input,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [7:0] cmd_data,
  input wire logic [7:0] cmd_char,
  input wire logic cmd_char_valid,
  input wire logic query_error,
  input wire logic device_error,
  input wire logic exec_error,
  input wire logic command_error,
  input wire logic ops_pending,
  input wire logic [7:0] catalog_char,
  input wire logic rsp_read,
  input wire logic [7:0] keyword_c4,
  output logic keyword_three_ok,
  output logic [7:0] rsp_data,
  output logic rsp_valid,
  output logic [7:0] instrument_condition,
  output logic [7:0] summary_status_byte,
  output logic service_request,
  output logic [7:0] last_cmd_char,
  output logic [7:0] last_rsp_char
);

  ssr_state_t cur_ff;
  ssr_state_t nxt_st;
  logic [7:0] ic_now;
  logic [7:0] sb_now;
  logic rsp_load;
  logic [7:0] rsp_word;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Two synchroniser stages that agree count as a change, else hold
  function automatic logic sync_level(input logic [2:0] s,
                                      input logic prev);
    sync_level = (s[1] == s[2]) ? s[2] : prev;
  endfunction : sync_level

  function automatic logic is_vowel(input logic [7:0] c);
    logic [7:0] u;
    u = c & 8'hDF;
    is_vowel = (u == 8'h41) || (u == 8'h45) || (u == 8'h49) ||
               (u == 8'h4F) || (u == 8'h55);
  endfunction : is_vowel

  ////////////////////////////////////////////////////////////////////
  // Condition and summary

  always_comb begin
    ic_now = `SSR_BYTE_ZERO;
    ic_now[`SSR_IC_ALARM] = sync_level(cur_ff.alarm_sy,
                                       cur_ff.ic_held[`SSR_IC_ALARM]);
    ic_now[`SSR_IC_HEATER] = sync_level(cur_ff.heater_sy,
                                        cur_ff.ic_held[`SSR_IC_HEATER]);
    ic_now[`SSR_IC_SF_FIRST] = sync_level(cur_ff.sf1_sy,
                                          cur_ff.ic_held[`SSR_IC_SF_FIRST]);
    ic_now[`SSR_IC_SF_SECOND] = sync_level(cur_ff.sf2_sy,
                                           cur_ff.ic_held[`SSR_IC_SF_SECOND]);
    sb_now = `SSR_BYTE_ZERO;
    sb_now[`SSR_SB_IE] = |(ic_now & cur_ff.ic_mask);
    sb_now[`SSR_SB_SE] = |(cur_ff.se_flags & cur_ff.se_mask);
    sb_now[`SSR_SB_MAV] = cur_ff.rsp_valid;
    sb_now[`SSR_SB_RQS] = cur_ff.srq;
  end

  ////////////////////////////////////////////////////////////////////
  // Response selection

  always_comb begin
    rsp_load = cmd_valid;
    rsp_word = `SSR_BYTE_ZERO;
    case (cmd_code)
      `SSR_CMD_RD_IC: rsp_word = ic_now;
      `SSR_CMD_RD_IC_MASK: rsp_word = cur_ff.ic_mask;
      `SSR_CMD_RD_SE: rsp_word = cur_ff.se_flags;
      `SSR_CMD_RD_SE_MASK: rsp_word = cur_ff.se_mask;
      `SSR_CMD_RD_SB: rsp_word = sb_now;
      `SSR_CMD_RD_SR_MASK: rsp_word = cur_ff.sr_mask;
      `SSR_CMD_CATALOG: rsp_word = catalog_char;
      default: rsp_load = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st = cur_ff;
    nxt_st.alarm_sy = {cur_ff.alarm_sy[1:0], alarm_pin};
    nxt_st.heater_sy = {cur_ff.heater_sy[1:0], heater_fault_pin};
    nxt_st.sf1_sy = {cur_ff.sf1_sy[1:0], sensor_fault_first_input};
    nxt_st.sf2_sy = {cur_ff.sf2_sy[1:0], sensor_fault_second_input};
    nxt_st.ic_held = ic_now;
    // clear status, before new events so sets win
    if (cmd_valid && cmd_code == `SSR_CMD_CLEAR) begin
      nxt_st.se_flags = `SSR_BYTE_ZERO;
      nxt_st.rsp_valid = 1'b0;
      nxt_st.opc_state = SSR_IDLE;
    end
    if (rsp_read) begin
      nxt_st.rsp_valid = 1'b0;
    end
    if (rsp_load) begin
      nxt_st.rsp_valid = 1'b1;
      nxt_st.rsp_data = rsp_word;
      nxt_st.last_rsp = rsp_word;
    end
    if (cmd_valid && cmd_code == `SSR_CMD_SET_IC_MASK) begin
      nxt_st.ic_mask = cmd_data & `SSR_IC_DEFINED;
    end
    if (cmd_valid && cmd_code == `SSR_CMD_SET_SE_MASK) begin
      nxt_st.se_mask = cmd_data & `SSR_SE_DEFINED;
    end
    if (cmd_valid && cmd_code == `SSR_CMD_SET_SR_MASK) begin
      nxt_st.sr_mask = cmd_data & `SSR_SB_DEFINED;
    end
    if (cmd_valid && cmd_code == `SSR_CMD_OPC) begin
      nxt_st.opc_state = SSR_OPC_WAIT;
    end
    case (cur_ff.opc_state)
      SSR_OPC_WAIT: begin
        if (!ops_pending) begin
          nxt_st.se_flags[`SSR_SE_OPC] = 1'b1;
          nxt_st.opc_state = SSR_IDLE;
        end
      end
      default: ;
    endcase
    if (query_error) begin
      nxt_st.se_flags[`SSR_SE_QUERY_ERR] = 1'b1;
    end
    if (device_error) begin
      nxt_st.se_flags[`SSR_SE_DEVICE_ERR] = 1'b1;
    end
    if (exec_error) begin
      nxt_st.se_flags[`SSR_SE_EXEC_ERR] = 1'b1;
    end
    if (command_error) begin
      nxt_st.se_flags[`SSR_SE_CMD_ERR] = 1'b1;
    end
    if (!cur_ff.power_seen) begin
      nxt_st.power_seen = 1'b1;
      nxt_st.se_flags[`SSR_SE_POWER_ON] = 1'b1;
    end
    if (cmd_char_valid) begin
      nxt_st.last_cmd = cmd_char;
    end
    nxt_st.srq = |(sb_now & cur_ff.sr_mask & `SSR_SB_DEFINED);
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cur_ff <= '0;
    end else if (clk_en) begin
      cur_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  // three letter form allowed when fourth is a vowel
  assign keyword_three_ok = is_vowel(keyword_c4);
  assign rsp_data = cur_ff.rsp_data;
  assign rsp_valid = cur_ff.rsp_valid;
  assign instrument_condition = ic_now;
  assign summary_status_byte = sb_now;
  assign service_request = cur_ff.srq;
  assign last_cmd_char = cur_ff.last_cmd;
  assign last_rsp_char = cur_ff.last_rsp;

endmodule : ssr_status

/* File: test/ssr_status_assertions.sv */
// Checker of the status block outputs
`timescale 1ns/1ps
`include "ssr_consts.svh"
module ssr_status_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic rsp_read,
  input wire logic [7:0] keyword_c4,
  input wire logic keyword_three_ok,
  input wire logic rsp_valid,
  input wire logic [7:0] instrument_condition,
  input wire logic [7:0] summary_status_byte,
  input wire logic service_request
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_undef_zero: assert property ({instrument_condition[6:5],
    instrument_condition[3:2], summary_status_byte[7],
    summary_status_byte[2:0]} == 8'h00) else $error("undefined bit set");
  a_mav_level: assert property (summary_status_byte[4] == rsp_valid)
    else $error("mav mismatch");
  a_rsp_hold: assert property (rsp_valid && !rsp_read && !cmd_valid
    |=> rsp_valid) else $error("response lost");
  a_read_answer: assert property (cmd_valid
    && cmd_code inside {[4'h6:4'hC]} |=> rsp_valid) else $error("no answer");
  a_clear_drop: assert property (cmd_valid && cmd_code == `SSR_CMD_CLEAR
    |=> !rsp_valid) else $error("clear kept response");
  a_srq_cause: assert property (service_request
    |-> $past(summary_status_byte[5:3]) != 3'h0) else $error("srq no cause");
  a_rqs_bit: assert property (summary_status_byte[6] == service_request)
    else $error("rqs mismatch");
  a_vowel_short: assert property (keyword_three_ok ==
    ((keyword_c4 | 8'h20) inside {8'h61, 8'h65, 8'h69, 8'h6F, 8'h75}))
    else $error("short form wrong");
  c_srq: cover property (service_request);
  c_consume: cover property (rsp_valid && rsp_read);
  c_clear: cover property (cmd_valid && cmd_code == `SSR_CMD_CLEAR);
endmodule : ssr_status_chk
bind ssr_status ssr_status_chk chk (.*);

/* File: test/ssr_host_model.sv */
// Host model issuing commands and consuming answers
`timescale 1ns/1ps
module ssr_host_model (
  input wire logic clock,
  input wire logic [7:0] rsp_data,
  output logic cmd_valid,
  output logic [3:0] cmd_code,
  output logic [7:0] cmd_data,
  output logic rsp_read
);
  initial {cmd_valid, cmd_code, cmd_data, rsp_read} = '0;
  task automatic send(input logic [3:0] c, input logic [7:0] d);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = d;
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_data = ~d;
  endtask : send
  task automatic query(input logic [3:0] c, output logic [7:0] d);
    send(c, 8'h00);
    d = rsp_data;
    rsp_read = 1'b1;
    @(negedge clock);
    rsp_read = 1'b0;
  endtask : query
endmodule : ssr_host_model

/* File: test/tb_status_service_request.sv */
// Self-checking bench of the status block
`timescale 1ns/1ps
`include "ssr_consts.svh"
`define CHK(a, b) check((a) === (b))
module tb_status_service_request;
  logic clock, reset, al, ht, f1, f2, cv, qe, de, ee, ce, ops, rr;
  logic kok, rv, srq, en, ccv;
  logic [7:0] cch, lcc;
  logic [3:0] code;
  logic [7:0] cd, cat, kc4, rd, ic, sb, lrc, d;
  logic [23:0] rows [6] = '{24'h808001, 24'h481021, 24'h240231,
    24'h120139, 24'hF1933D, 24'h00003D};
  int n_fail = 0, comparisons = 0;
  ssr_status dut (.clock(clock), .reset(reset), .clk_en(en),
    .alarm_pin(al), .heater_fault_pin(ht), .sensor_fault_first_input(f1),
    .sensor_fault_second_input(f2), .cmd_valid(cv), .cmd_code(code),
    .cmd_data(cd), .cmd_char(cch), .cmd_char_valid(ccv),
    .query_error(qe), .device_error(de), .exec_error(ee),
    .command_error(ce), .ops_pending(ops), .catalog_char(cat),
    .rsp_read(rr), .keyword_c4(kc4), .keyword_three_ok(kok),
    .rsp_data(rd), .rsp_valid(rv), .instrument_condition(ic),
    .summary_status_byte(sb), .service_request(srq), .last_cmd_char(lcc),
    .last_rsp_char(lrc));
  ssr_host_model host (.clock(clock), .rsp_data(rd), .cmd_valid(cv),
    .cmd_code(code), .cmd_data(cd), .rsp_read(rr));
  task automatic check(input bit ok);
    comparisons++;
    n_fail += int'(!ok);
    if (!ok) $display("ERROR %0t value mismatch", $time);
  endtask : check
  task automatic report_and_stop;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    reset = 1'b1;
    en = 1'b1;
    ccv = 1'b0;
    cch = 8'h00;
    {al, ht, f1, f2, qe, de, ee, ce, cat, kc4, ops} = {16'h0, 9'hDF};
    repeat (3) @(negedge clock);
    reset = 1'b0;
    host.send(`SSR_CMD_OPC, 8'h00);
    for (int i = 0; i < 3; i++) begin
      host.send(4'(i + 1), 8'hFF);
      host.query(4'(2 * i + 7), d);
      `CHK(d, 8'(24'h93BD38 >> (16 - 8 * i)));
    end
    foreach (rows[i]) begin
      {al, ht, f2, f1, qe, de, ee, ce} = rows[i][23:16];
      @(negedge clock);
      {qe, de, ee, ce} = 4'h0;
      repeat (2) @(negedge clock);
      `CHK({sb[3], ic}, {|rows[i][15:8], rows[i][15:8]});
      host.query(`SSR_CMD_RD_SE, d);
      `CHK(d, rows[i][7:0]);
      $display("row %0d done", i);
    end
    ops = 1'b0;
    host.query(`SSR_CMD_RD_SE, d);
    `CHK({d, sb[5], srq, kok}, 11'h5EF);
    host.send(`SSR_CMD_CLEAR, 8'h00);
    @(negedge clock);
    `CHK({sb, srq}, 9'h000);
    cat = 8'h2C;
    host.send(`SSR_CMD_CATALOG, 8'h00);
    @(negedge clock);
    `CHK({rd, lrc, sb[4], srq}, 18'h0B0B3);
    cch = 8'h3A;
    ccv = 1'b1;
    @(negedge clock);
    ccv = 1'b0;
    cch = 8'h00;
    @(negedge clock);
    `CHK(lcc, 8'h3A);
    en = 1'b0;
    host.send(`SSR_CMD_SET_SR_MASK, 8'h00);
    en = 1'b1;
    host.query(`SSR_CMD_RD_SR_MASK, d);
    `CHK(d, 8'h38);
    $display("freeze and command echo done");
    reset = 1'b1;
    @(negedge clock);
    `CHK({sb, srq, rv}, 10'h000);
    reset = 1'b0;
    host.query(`SSR_CMD_RD_SE, d);
    `CHK(d, 8'h01);
    $display("mid-run reset done");
    report_and_stop();
  end
endmodule : tb_status_service_request
